// ### hvm_pkg.sv
// Package of constants and types for the mainframe lock and panel control.
package hvm_pkg;
    localparam int CLK_HZ = 25000000;
    // Beep and flash timing.
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int BLINK_MS = 250;
    localparam int FLICKER_MS = 62;
    localparam int COUNTDOWN_S = 10;
    localparam int BEEP_MS = 100;
    localparam int NOMOD_BEEP_PERIOD_MS = 1000;
    localparam int POWERUP_LIMIT_S = 1;

    // Register map, byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SET_CODE = 8'h08;
    localparam logic [7:0] REG_LIM_CODE = 8'h0C;
    localparam logic [7:0] REG_COMMIT = 8'h10;
    localparam logic [7:0] REG_EDIT = 8'h14;
    localparam logic [7:0] REG_ACTIVE = 8'h18;
    localparam logic [7:0] REG_SYSDEF = 8'h1C;

    // Control register bit positions (write one to act).
    localparam int CTRL_GEN_ON = 0;
    localparam int CTRL_GEN_OFF = 1;
    localparam int CTRL_REMOTE_SRC = 2;
    localparam int CTRL_LOCK_SET = 3;
    localparam int CTRL_UNLOCK_SET = 4;
    localparam int CTRL_LOCK_LIM = 5;
    localparam int CTRL_UNLOCK_LIM = 6;
    localparam int CTRL_CLR_ERR = 7;
    localparam int CTRL_INT_ERR = 8;
    localparam int CTRL_RESTORE_OK = 9;
    localparam int CTRL_RESTORE_ERR = 10;
    localparam int CTRL_NEW_CONFIG = 11;
    localparam int CTRL_POWERUP_DONE = 12;
    localparam int CTRL_WAS_ACTIVE = 13;

    // Status register bit positions.
    localparam int ST_GEN = 0;
    localparam int ST_SET_LOCK = 1;
    localparam int ST_LIM_LOCK = 2;
    localparam int ST_AUTO_EN = 3;
    localparam int ST_PW_EN = 4;
    localparam int ST_THERM = 5;
    localparam int ST_SUPPLY_BAD = 6;
    localparam int ST_CODE_ERR = 7;
    localparam int ST_REJECT = 8;
    localparam int ST_COUNTDOWN = 9;
    localparam int ST_PANIC = 10;
    localparam int ST_NOMOD = 11;

    // System defaults register bits.
    localparam int SD_AUTO_EN = 0;
    localparam int SD_PW_EN = 1;
    localparam int SD_STATUS_OFF = 2;

    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [31:0] ACTIVE_RESET = 32'h00000000;

    typedef enum logic [1:0] {
        HVM_VIEW_SYSTEM,
        HVM_VIEW_GROUP,
        HVM_VIEW_CHAN
    } hvm_view_e;
endpackage

// ### hvm_light_if.sv
// Interface carrying indicator inputs from the core into the light driver.
interface hvm_light_if;
    logic       tick;
    logic       gen_on;
    logic       ramping;
    logic       countdown;
    logic       panic;
    logic       interlock;
    logic       any_trip;
    logic [3:0] slot_present;
    logic [3:0] slot_busy;
    logic       remote_mode;
    logic       net_active;
    logic [1:0] view;
    logic       gen_light;
    logic       fault_light;
    logic       panic_light;
    logic       ilk_light;
    logic       remote_light;
    logic       net_light;
    logic [2:0] view_light;
    logic [3:0] slot_light;

    modport core (output tick, gen_on, ramping, countdown, panic, interlock, any_trip,
                  slot_present, slot_busy, remote_mode, net_active, view,
                  input gen_light, fault_light, panic_light, ilk_light, remote_light,
                  net_light, view_light, slot_light);
    modport drv (input tick, gen_on, ramping, countdown, panic, interlock, any_trip,
                 slot_present, slot_busy, remote_mode, net_active, view,
                 output gen_light, fault_light, panic_light, ilk_light, remote_light,
                 net_light, view_light, slot_light);
endinterface

// ### hvm_lights.sv
// Front panel indicator driver with blink and flicker phases.
module hvm_lights
    import hvm_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Core side
    hvm_light_if.drv  lif
);
    typedef struct packed {
        logic [9:0] blink_cnt;
        logic [9:0] flick_cnt;
        logic       blink;
        logic       flick;
        logic       gen_light;
        logic       fault_light;
        logic       panic_light;
        logic       ilk_light;
        logic       remote_light;
        logic       net_light;
        logic [2:0] view_light;
        logic [3:0] slot_light;
    } hvm_lights_s;

    localparam logic [9:0] BLINK_TICKS = 10'(BLINK_MS - 1);
    localparam logic [9:0] FLICK_TICKS = 10'(FLICKER_MS - 1);

    hvm_lights_s r;
    hvm_lights_s next_r;

    always_comb begin
        next_r = r;
        if (lif.tick) begin
            if (r.blink_cnt == BLINK_TICKS) begin
                next_r.blink_cnt = '0;
                next_r.blink = ~r.blink;
            end else begin
                next_r.blink_cnt = r.blink_cnt + 10'h001;
            end
            if (r.flick_cnt == FLICK_TICKS) begin
                next_r.flick_cnt = '0;
                next_r.flick = ~r.flick;
            end else begin
                next_r.flick_cnt = r.flick_cnt + 10'h001;
            end
        end
        next_r.panic_light = lif.panic;
        next_r.ilk_light = lif.panic & lif.interlock;
        next_r.fault_light = lif.any_trip & r.blink;
        if (lif.countdown) begin
            next_r.gen_light = r.blink;
        end else if (lif.gen_on && lif.ramping) begin
            next_r.gen_light = r.flick;
        end else begin
            next_r.gen_light = lif.gen_on;
        end
        next_r.remote_light = lif.remote_mode;
        next_r.net_light = lif.net_active;
        case (hvm_view_e'(lif.view))
            HVM_VIEW_GROUP: next_r.view_light = 3'h2;
            HVM_VIEW_CHAN: next_r.view_light = 3'h4;
            default: next_r.view_light = 3'h1;
        endcase
        for (int i = 0; i < 4; i++) begin
            next_r.slot_light[i] = lif.slot_present[i]
                & (~lif.slot_busy[i] | r.blink);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign lif.gen_light = r.gen_light;
    assign lif.fault_light = r.fault_light;
    assign lif.panic_light = r.panic_light;
    assign lif.ilk_light = r.ilk_light;
    assign lif.remote_light = r.remote_light;
    assign lif.net_light = r.net_light;
    assign lif.view_light = r.view_light;
    assign lif.slot_light = r.slot_light;
endmodule

// ### hvm_core.sv
// Mainframe supervisory core: locks, auto restart, thermal trip, panel keys.
module hvm_core
    import hvm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Front panel keys and switches
    input  wire logic        key_gen_on,
    input  wire logic        key_gen_off,
    input  wire logic        key_panic,
    input  wire logic        key_commit,
    input  wire logic        key_any,
    input  wire logic        key_remote_pos,
    input  wire logic        interlock_n,
    input  wire logic        thermal_fault,
    input  wire logic        net_active,
    input  wire logic [1:0]  view_sel,
    // Module status
    input  wire logic [3:0]  slot_present,
    input  wire logic [3:0]  slot_ramping,
    input  wire logic [3:0]  slot_tripped,
    // Outputs to modules and panel
    output logic             generation_active,
    output logic             supply_24v_en,
    output logic             status_out,
    output logic             beep,
    output logic             warn_thermal,
    output logic             generation_active_light,
    output logic             channel_fault_light,
    output logic             panic_light,
    output logic             interlock_light,
    output logic             remote_light,
    output logic             network_light,
    output logic [2:0]       view_light,
    output logic [3:0]       slot_light
);
    localparam logic [9:0] SEC_TICKS = 10'(1000 - 1);
    localparam logic [9:0] BEEP_TICKS = 10'(BEEP_MS);
    localparam logic [3:0] CD_SECS = 4'(COUNTDOWN_S);
    localparam int TCW = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [TCW-1:0] tick_cnt;
        logic           tick;
        logic [9:0]     ms_cnt;
        logic [3:0]     cd_left;
        logic           countdown;
        logic           gen;
        logic           set_lock;
        logic           lim_lock;
        logic [15:0]    set_code;
        logic [15:0]    lim_code;
        logic           auto_en;
        logic           pw_en;
        logic           status_on_off;
        logic           was_active;
        logic           therm;
        logic           panic;
        logic           panic_ilk;
        logic           code_err;
        logic           reject;
        logic           nomod;
        logic [31:0]    edit;
        logic [31:0]    active;
        logic           ack;
        logic [31:0]    rdata;
        logic [8:0]     sync;
        logic [8:0]     pins;
        logic           cmt_d;
        logic           any_d;
    } hvm_core_s;

    hvm_core_s r;
    hvm_core_s next_r;
    hvm_light_if lif ();

    logic        wr;
    logic        rd;
    logic [15:0] ctrl;
    logic [15:0] wcode;
    logic        p_on;
    logic        p_off;
    logic        p_panic;
    logic        p_commit;
    logic        p_any;
    logic        p_remote;
    logic        p_ilk;
    logic        p_therm;
    logic        p_net;
    logic        remote_ok;
    logic        local_ok;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~r.ack;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~r.ack;
    assign ctrl = (wr && wb_adr_i == REG_CTRL) ? wb_dat_i[15:0] : 16'h0000;
    assign wcode = wb_dat_i[15:0];
    assign {p_net, p_therm, p_ilk, p_remote, p_any, p_commit, p_panic, p_off, p_on} = r.pins;
    assign remote_ok = p_remote;
    assign local_ok = ~p_remote;

    always_comb begin
        next_r = r;
        // Key, interlock, thermal and network pins are double-registered before any decision uses them.
        next_r.sync = {net_active, thermal_fault, ~interlock_n, key_remote_pos, key_any,
                       key_commit, key_panic, key_gen_off, key_gen_on};
        next_r.pins = r.sync;
        next_r.cmt_d = p_commit;
        next_r.any_d = p_any;
        next_r.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        next_r.reject = 1'b0;

        next_r.tick = 1'b0;
        if (r.tick_cnt == TCW'(TICK_CYCLES - 1)) begin
            next_r.tick_cnt = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.tick_cnt = r.tick_cnt + TCW'(1);
        end
        if (r.tick) begin
            next_r.ms_cnt = (r.ms_cnt == SEC_TICKS) ? 10'h000 : r.ms_cnt + 10'h001;
        end

        // Locks: each has its own flag and code, independent of key switch.
        if (wr && wb_adr_i == REG_SET_CODE) begin
            if (!r.set_lock) begin
                next_r.set_lock = 1'b1;
                next_r.set_code = wcode;
            end else if (wcode == r.set_code) begin
                next_r.set_lock = 1'b0;
                next_r.set_code = CODE_RESET;
            end else begin
                next_r.code_err = 1'b1;
            end
        end
        if (wr && wb_adr_i == REG_LIM_CODE) begin
            if (!r.lim_lock) begin
                next_r.lim_lock = 1'b1;
                next_r.lim_code = wcode;
            end else if (wcode == r.lim_code) begin
                next_r.lim_lock = 1'b0;
                next_r.lim_code = CODE_RESET;
            end else begin
                next_r.code_err = 1'b1;
            end
        end
        if (ctrl[CTRL_CLR_ERR]) begin
            next_r.code_err = 1'b0;
        end

        // Editing never touches active settings until commit.
        if (wr && wb_adr_i == REG_EDIT) begin
            next_r.edit = wb_dat_i;
        end
        if ((p_commit && !r.cmt_d) || (wr && wb_adr_i == REG_COMMIT)) begin
            if (r.set_lock) begin
                next_r.reject = 1'b1;
            end else begin
                next_r.active = r.edit;
            end
        end

        if (wr && wb_adr_i == REG_SYSDEF) begin
            next_r.auto_en = wb_dat_i[SD_AUTO_EN];
            next_r.pw_en = wb_dat_i[SD_PW_EN];
            next_r.status_on_off = wb_dat_i[SD_STATUS_OFF];
        end
        if (ctrl[CTRL_WAS_ACTIVE]) begin
            next_r.was_active = 1'b1;
        end

        // Generation on and off ignore the locks.
        if ((p_on && local_ok) || (ctrl[CTRL_GEN_ON] && ctrl[CTRL_REMOTE_SRC] && remote_ok)) begin
            if (!r.therm) begin
                next_r.gen = 1'b1;
            end
        end
        if (p_off || ctrl[CTRL_GEN_OFF]) begin
            next_r.gen = 1'b0;
            next_r.countdown = 1'b0;
        end

        // Restart countdown after mains loss.
        if (ctrl[CTRL_RESTORE_OK] && r.auto_en && r.was_active) begin
            next_r.countdown = 1'b1;
            next_r.cd_left = CD_SECS;
            next_r.ms_cnt = 10'h000;
        end
        if (r.countdown) begin
            if (p_any && !r.any_d) begin
                next_r.countdown = 1'b0;
            end else if (r.tick && r.ms_cnt == SEC_TICKS) begin
                if (r.cd_left == 4'h1) begin
                    next_r.countdown = 1'b0;
                    next_r.gen = 1'b1;
                end
                next_r.cd_left = r.cd_left - 4'h1;
            end
        end

        // Emergency shutdown from key or interlock.
        if (p_panic || p_ilk) begin
            next_r.panic = 1'b1;
            next_r.panic_ilk = p_ilk;
            next_r.gen = 1'b0;
            next_r.countdown = 1'b0;
        end else if (p_on && local_ok) begin
            next_r.panic = 1'b0;
            next_r.panic_ilk = 1'b0;
        end

        // Thermal overload latches until power cycle, without shutdown.
        if (p_therm) begin
            next_r.therm = 1'b1;
        end
        if (r.therm) begin
            next_r.gen = 1'b0;
            next_r.countdown = 1'b0;
        end

        if (ctrl[CTRL_POWERUP_DONE] && slot_present == 4'h0) begin
            next_r.nomod = 1'b1;
        end
        if (r.nomod) begin
            next_r.set_lock = 1'b0;
            next_r.lim_lock = 1'b0;
            next_r.pw_en = 1'b0;
            next_r.auto_en = 1'b0;
        end
        if (ctrl[CTRL_NEW_CONFIG] || ctrl[CTRL_RESTORE_ERR] || ctrl[CTRL_INT_ERR]
            || p_panic || r.nomod) begin
            next_r.auto_en = 1'b0;
            next_r.countdown = ctrl[CTRL_RESTORE_ERR] ? 1'b0 : next_r.countdown;
        end

        next_r.rdata = 32'h00000000;
        if (rd) begin
            if (wb_adr_i == REG_STATUS) begin
                next_r.rdata[ST_GEN] = r.gen;
                next_r.rdata[ST_SET_LOCK] = r.set_lock;
                next_r.rdata[ST_LIM_LOCK] = r.lim_lock;
                next_r.rdata[ST_AUTO_EN] = r.auto_en;
                next_r.rdata[ST_PW_EN] = r.pw_en;
                next_r.rdata[ST_THERM] = r.therm;
                next_r.rdata[ST_SUPPLY_BAD] = r.therm;
                next_r.rdata[ST_CODE_ERR] = r.code_err;
                next_r.rdata[ST_REJECT] = r.reject;
                next_r.rdata[ST_COUNTDOWN] = r.countdown;
                next_r.rdata[ST_PANIC] = r.panic;
                next_r.rdata[ST_NOMOD] = r.nomod;
            end else if (wb_adr_i == REG_EDIT) begin
                next_r.rdata = r.edit;
            end else if (wb_adr_i == REG_ACTIVE) begin
                next_r.rdata = r.active;
            end else if (wb_adr_i == REG_SYSDEF) begin
                next_r.rdata[SD_AUTO_EN] = r.auto_en;
                next_r.rdata[SD_PW_EN] = r.pw_en;
                next_r.rdata[SD_STATUS_OFF] = r.status_on_off;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
            r.active <= ACTIVE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Light driver shares the millisecond tick so every flash stays in phase.
    assign lif.tick = r.tick;
    assign lif.gen_on = r.gen;
    assign lif.ramping = |(slot_ramping & slot_present);
    assign lif.countdown = r.countdown;
    assign lif.panic = r.panic;
    assign lif.interlock = r.panic_ilk;
    assign lif.any_trip = |(slot_tripped & slot_present);
    assign lif.slot_present = slot_present;
    assign lif.slot_busy = slot_ramping | slot_tripped;
    assign lif.remote_mode = p_remote;
    assign lif.net_active = p_net;
    assign lif.view = view_sel;

    hvm_lights u_lights (
        .core_clk (core_clk),
        .resetn   (resetn),
        .lif      (lif)
    );

    assign generation_active = r.gen;
    assign supply_24v_en = ~r.therm;
    assign status_out = r.status_on_off & ~r.gen;
    assign warn_thermal = r.therm;
    // Short beep each countdown second; double beep each second when no modules.
    assign beep = (r.countdown && r.ms_cnt < BEEP_TICKS)
        || (r.nomod && (r.ms_cnt < BEEP_TICKS
            || (r.ms_cnt >= 10'(2 * BEEP_MS) && r.ms_cnt < 10'(3 * BEEP_MS))));
    assign generation_active_light = lif.gen_light;
    assign channel_fault_light = lif.fault_light;
    assign panic_light = lif.panic_light;
    assign interlock_light = lif.ilk_light;
    assign remote_light = lif.remote_light;
    assign network_light = lif.net_light;
    assign view_light = lif.view_light;
    assign slot_light = lif.slot_light;
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdata;
endmodule

// ### hvm_core_checker.sv
// Port-level assertions for the mainframe supervisory core.
module hvm_core_checker (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // Inputs watched
    input wire logic       key_panic,
    input wire logic       thermal_fault,
    input wire logic       net_active,
    // Outputs watched
    input wire logic       generation_active,
    input wire logic       supply_24v_en,
    input wire logic       warn_thermal,
    input wire logic       panic_light,
    input wire logic       network_light,
    input wire logic [2:0] view_light
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_cut_supply: assert property ($rose(thermal_fault) |-> ##[1:4] !supply_24v_en)
        else $error("supply not cut");
    a_cut_persists: assert property (!supply_24v_en |=> !supply_24v_en)
        else $error("supply came back");
    a_cut_stops_gen: assert property (!supply_24v_en ##1 !supply_24v_en |-> !generation_active)
        else $error("generation with supply cut");
    a_cut_warns: assert property (!supply_24v_en |-> ##[0:2] warn_thermal)
        else $error("no thermal warning");
    a_cut_no_panic: assert property ($fell(supply_24v_en) && !panic_light |=> !panic_light)
        else $error("overload raised shutdown");
    a_panic_stop: assert property (key_panic [*3] |=> ##[0:2] (!generation_active && panic_light))
        else $error("shutdown key ignored");
    a_net_light: assert property ($rose(net_active) |-> ##[2:5] network_light)
        else $error("network light off");
    a_view_onehot: assert property ($past(resetn) |-> $onehot(view_light))
        else $error("view lights not one-hot");
    c_cut: cover property (!supply_24v_en);
    c_panic: cover property (panic_light);
    c_net: cover property (network_light);
endmodule

bind hvm_core hvm_core_checker u_chk (.core_clk, .resetn, .key_panic, .thermal_fault,
    .net_active, .generation_active, .supply_24v_en, .warn_thermal, .panic_light,
    .network_light, .view_light);

// ### hvm_rack_model.sv
// Behavioural module rack: slot population and channel ramp and trip states.
module hvm_rack_model (
    // Clock
    input  wire logic       core_clk,
    // Bench requests
    input  wire logic [3:0] fit,
    input  wire logic [3:0] ramp,
    input  wire logic [3:0] trip,
    // Module status
    output logic      [3:0] slot_present,
    output logic      [3:0] slot_ramping,
    output logic      [3:0] slot_tripped
);
    // An empty slot can report no channel activity, as in a real rack.
    always_ff @(posedge core_clk) begin
        slot_present <= fit;
        slot_ramping <= ramp & fit;
        slot_tripped <= trip & fit;
    end
endmodule

// ### hvm_core_tb_top.sv
// Self-checking bench for the mainframe supervisory core.
module hvm_core_tb_top
    import hvm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic        key_panic = 0, key_any = 0, key_remote_pos = 0, thermal_fault = 0;
    logic        net_active = 0, key_gen_on = 0, interlock_n = 1, il;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o;
    logic [1:0]  view_sel = 2'h0;
    logic [3:0]  fit = 4'hB, ramp = 4'h0, trip = 4'h0, sp, sr, st, sl;
    logic [2:0]  hi, lo, vl;
    logic        wb_ack_o, gen, sup, so, bp, wt, gl, fl, pl, rl, nl;
    int          failures = 0, compares = 0, cyc_n = 0, n, beeps;
    int          clr [3] = '{CTRL_NEW_CONFIG, CTRL_RESTORE_ERR, CTRL_INT_ERR};

    initial forever #20 core_clk = ~core_clk;

    hvm_rack_model u_rack (.core_clk, .fit, .ramp, .trip, .slot_present(sp),
        .slot_ramping(sr), .slot_tripped(st));
    hvm_core #(.TICK_CYCLES(2)) u_dut (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_dat_o, .wb_ack_o, .key_gen_on,
        .key_gen_off(1'b0), .key_panic, .key_commit(1'b0), .key_any, .key_remote_pos,
        .interlock_n, .thermal_fault, .net_active, .view_sel, .slot_present(sp),
        .slot_ramping(sr), .slot_tripped(st), .generation_active(gen), .supply_24v_en(sup),
        .status_out(so), .beep(bp), .warn_thermal(wt), .generation_active_light(gl),
        .channel_fault_light(fl), .panic_light(pl), .interlock_light(il), .remote_light(rl),
        .network_light(nl), .view_light(vl), .slot_light(sl));

    task automatic complete_run();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // Stops early once generation changes, so a countdown end is timed exactly.
    task automatic run(int max);
        logic g0, b0;
        g0 = gen;
        // A beep already sounding when the run starts counts as one.
        b0 = 1'b0;
        n = 0;
        beeps = 0;
        hi = 3'h0;
        lo = 3'h0;
        while (gen === g0 && n < max) begin
            @(posedge core_clk);
            n++;
            hi |= {fl, sl[0], gl};
            lo |= ~{fl, sl[0], gl};
            beeps += (bp === 1'b1 && b0 === 1'b0);
            b0 = bp;
        end
    endtask
    task automatic arm();
        wr(REG_CTRL, 32'h2);
        wr(REG_SYSDEF, 32'h1);
        wr(REG_CTRL, 32'h2000);
        wr(REG_CTRL, 32'h200);
    endtask
    task automatic hold(int c);
        repeat (c) @(posedge core_clk);
    endtask
    // The key passes two synchroniser stages, so it is held well past them.
    task automatic key_on();
        key_gen_on <= 1'b1;
        hold(4);
        key_gen_on <= 1'b0;
        hold(4);
    endtask

    always @(posedge core_clk) begin
        cyc_n++;
        if (cyc_n == 50000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        hold(12);
        resetn <= 1'b1;
        rdc(REG_STATUS, 32'hE, 32'h0);
        wr(REG_SET_CODE, 32'h1234);
        rdc(REG_STATUS, 32'h6, 32'h2);
        wr(REG_EDIT, 32'h5A);
        wr(REG_COMMIT, 32'h0);
        rdc(REG_ACTIVE, 32'hFFFFFFFF, 32'h0);
        key_on();
        chk(gen, 32'h1);
        wr(REG_SET_CODE, 32'h1235);
        rdc(REG_STATUS, 32'h82, 32'h82);
        key_remote_pos <= 1'b1;
        hold(4);
        wr(REG_SET_CODE, 32'h1234);
        rdc(REG_STATUS, 32'h6, 32'h0);
        wr(REG_CTRL, 32'h2);
        chk(gen, 32'h0);
        key_on();
        chk(gen, 32'h0);
        wr(REG_CTRL, 32'h5);
        chk({gen, rl}, 32'h3);
        wr(REG_SET_CODE, 32'h42);
        wr(REG_SET_CODE, 32'h1234);
        rdc(REG_STATUS, 32'h6, 32'h2);
        wr(REG_SET_CODE, 32'h42);
        wr(REG_LIM_CODE, 32'h7);
        rdc(REG_STATUS, 32'h6, 32'h4);
        wr(REG_LIM_CODE, 32'h7);
        wr(REG_EDIT, 32'h5A);
        rdc(REG_ACTIVE, 32'hFFFFFFFF, 32'h0);
        wr(REG_COMMIT, 32'h0);
        rdc(REG_ACTIVE, 32'hFFFFFFFF, 32'h5A);
        foreach (clr[i]) begin
            wr(REG_SYSDEF, 32'h1);
            rdc(REG_STATUS, 32'h8, 32'h8);
            wr(REG_CTRL, 32'h1 << clr[i]);
            rdc(REG_STATUS, 32'h8, 32'h0);
        end
        wr(REG_SYSDEF, 32'h1);
        wr(REG_CTRL, 32'h5);
        key_panic <= 1'b1;
        hold(5);
        key_panic <= 1'b0;
        chk({gen, pl, il}, 32'h2);
        rdc(REG_STATUS, 32'h408, 32'h400);
        key_remote_pos <= 1'b0;
        hold(4);
        key_on();
        chk({gen, pl}, 32'h2);
        interlock_n <= 1'b0;
        hold(5);
        interlock_n <= 1'b1;
        chk({gen, pl, il}, 32'h3);
        arm();
        run(25000);
        chk(n >= 19900 && n <= 20100, 32'h1);
        chk(beeps, 32'hA);
        chk(hi[0] & lo[0], 32'h1);
        ramp <= 4'h1;
        trip <= 4'h1;
        run(1500);
        chk(hi & lo, 32'h7);
        ramp <= 4'h0;
        trip <= 4'h0;
        net_active <= 1'b1;
        hold(8);
        chk({fl, sl, gl, nl}, 32'h2F);
        for (int v = 0; v < 4; v++) begin
            view_sel <= v[1:0];
            hold(6);
            chk(vl, (v == 1) ? 32'h2 : (v == 2) ? 32'h4 : 32'h1);
        end
        arm();
        key_any <= 1'b1;
        hold(6);
        key_any <= 1'b0;
        run(300);
        rdc(REG_STATUS, 32'h201, 32'h0);
        wr(REG_SYSDEF, 32'h4);
        key_on();
        chk(gen, 32'h1);
        thermal_fault <= 1'b1;
        hold(6);
        thermal_fault <= 1'b0;
        hold(6);
        chk({gen, sup, wt, so}, 32'h3);
        rdc(REG_STATUS, 32'h461, 32'h60);
        resetn <= 1'b0;
        hold(3);
        resetn <= 1'b1;
        wr(REG_SET_CODE, 32'h99);
        chk(sup, 32'h1);
        wr(REG_SYSDEF, 32'h3);
        fit <= 4'h0;
        hold(3);
        wr(REG_CTRL, 32'h1000);
        rdc(REG_STATUS, 32'h81E, 32'h800);
        run(4000);
        chk(beeps >= 4 && beeps <= 5, 32'h1);
        complete_run();
    end
endmodule
